/* File: hdl/dhi_ctrl.sv */
/*
 Interface-side control of a moving-head disc drive: error latch clearing,
 standby and start sequencing, head and zone selection, gates and bit clocks.
 Assumes mechanism status (speed, retract, recal, offset) arrives as levels.
*/
`timescale 1ns/1ps
module dhi_ctrl
   import dhi_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Host command levels
   input wire logic i_standby_req,
   input wire logic i_head_load_permit,
   input wire logic i_powerup_chain_input,
   input wire logic i_chain_permit_in,
   input wire logic i_read_gate,
   input wire logic i_write_gate,
   input wire logic [HEAD_W-1:0] i_head_addr,
   input wire logic [ZONE_W-1:0] i_cyl_zone,
   input wire logic i_port1_ind,
   input wire logic i_port2_ind,
   input wire logic i_offset_reset,
   input wire logic i_motion_go,
   // Serial data line
   input wire logic i_data_in,
   output logic o_data_out,
   output logic o_data_oe_b,
   // Drive mechanism and operator
   input wire logic i_start_req,
   input wire logic i_pack_present,
   input wire logic i_door_closed,
   input wire logic i_at_speed,
   input wire logic i_fully_retracted,
   input wire logic i_heads_loaded_mech,
   input wire logic i_stop_cond,
   input wire logic i_index_pulse,
   input wire logic i_index_bad,
   input wire logic i_seek_timeout,
   input wire logic i_recal_done,
   input wire logic i_seek_done,
   input wire logic i_at_offset,
   input wire logic i_read_bit,
   input wire logic [UNIT_W-1:0] i_plug_addr,
   // Status toward host
   output logic o_drive_ready,
   output logic o_heads_loaded,
   output logic o_carriage_home,
   output logic o_offset_reached,
   output logic o_index_fault,
   output logic o_safety_stop,
   output logic o_seek_timeout,
   output logic o_chain_permit_out,
   output logic o_osc_clk,
   output logic o_read_clk,
   output logic [UNIT_W-1:0] o_unit_num,
   // Mechanism and lamps
   output logic o_retract,
   output logic o_load_heads,
   output logic o_brake,
   output logic o_spindle_on,
   output logic o_recal_launch,
   output logic o_write_en,
   output logic o_write_bit,
   output logic [HEAD_W-1:0] o_head_sel,
   output logic o_head_sel_valid,
   output logic [LEVEL_W-1:0] o_write_level,
   output logic o_standby_lamp,
   output logic o_ready_lamp,
   output logic o_port1_lamp,
   output logic o_port2_lamp
);
   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers
   localparam int unsigned NSYNC = 11;
   logic [NSYNC-1:0] sync1_r;
   logic [NSYNC-1:0] sync2_r;
   logic standby_s, permit_s, chain_in_s, chain_ok_s, rgate_s, wgate_s;
   logic p1_s, p2_s, ofs_rst_s, go_s, start_s;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {i_standby_req, i_head_load_permit, i_powerup_chain_input,
                     i_chain_permit_in, i_read_gate, i_write_gate, i_port1_ind,
                     i_port2_ind, i_offset_reset, i_motion_go, i_start_req};
         sync2_r <= sync1_r;
      end
   end
   assign {standby_s, permit_s, chain_in_s, chain_ok_s, rgate_s, wgate_s,
           p1_s, p2_s, ofs_rst_s, go_s, start_s} = sync2_r;
   logic start_d_r;
   logic start_pulse;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         start_d_r <= RST_LOW;
      end else begin
         start_d_r <= start_s;
      end
   end
   assign start_pulse = start_s & ~start_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // Error latches
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_index_fault <= RST_LOW;
      end else if (i_index_bad) begin
         o_index_fault <= 1'b1;
      end else if (i_index_pulse) begin
         o_index_fault <= 1'b0;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_safety_stop <= RST_LOW;
      end else if (i_stop_cond) begin
         o_safety_stop <= 1'b1;
      end else if (start_pulse) begin
         o_safety_stop <= 1'b0;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_seek_timeout <= RST_LOW;
         o_recal_launch <= RST_LOW;
      end else begin
         o_recal_launch <= i_seek_timeout & ~o_seek_timeout;
         if (i_seek_timeout) begin
            o_seek_timeout <= 1'b1;
         end else if (i_recal_done) begin
            o_seek_timeout <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standby and power-up sequencer
   typedef enum logic [2:0] {ST_IDLE, ST_SPINUP, ST_LOAD, ST_READY, ST_RETRACT,
                             ST_BRAKE} dhi_seq_e;
   dhi_seq_e seq_r;
   logic start_ok;
   assign start_ok = permit_s & chain_in_s & chain_ok_s & i_pack_present
                     & i_door_closed & ~o_safety_stop;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seq_r <= ST_IDLE;
      end else begin
         case (seq_r)
            ST_IDLE: begin
               if (start_pulse && start_ok && !standby_s) begin
                  seq_r <= ST_SPINUP;
               end
            end
            ST_SPINUP: begin
               if (standby_s) begin
                  seq_r <= ST_RETRACT;
               end else if (i_at_speed && permit_s) begin
                  seq_r <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (standby_s || !permit_s) begin
                  seq_r <= ST_RETRACT;
               end else if (i_heads_loaded_mech) begin
                  seq_r <= ST_READY;
               end
            end
            ST_READY: begin
               if (standby_s || !permit_s) begin
                  seq_r <= ST_RETRACT;
               end
            end
            ST_RETRACT: begin
               if (i_fully_retracted) begin
                  seq_r <= standby_s ? ST_BRAKE : ST_SPINUP;
               end
            end
            ST_BRAKE: begin
               if (start_pulse && start_ok) begin
                  seq_r <= ST_SPINUP;
               end
            end
            default: seq_r <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_standby_lamp <= RST_LOW;
      end else if (standby_s && seq_r != ST_IDLE) begin
         o_standby_lamp <= 1'b1;
      end else if (seq_r == ST_BRAKE && start_pulse && start_ok) begin
         o_standby_lamp <= 1'b0;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_retract <= RST_LOW;
         o_load_heads <= RST_LOW;
         o_brake <= RST_LOW;
         o_spindle_on <= RST_LOW;
         o_heads_loaded <= RST_LOW;
         o_carriage_home <= RST_LOW;
         o_chain_permit_out <= RST_LOW;
      end else begin
         o_retract <= (seq_r == ST_RETRACT);
         o_load_heads <= (seq_r == ST_LOAD) & permit_s;
         o_brake <= (seq_r == ST_BRAKE);
         o_spindle_on <= (seq_r inside {ST_SPINUP, ST_LOAD, ST_READY});
         o_heads_loaded <= (seq_r == ST_READY);
         o_carriage_home <= i_fully_retracted & (seq_r inside {ST_RETRACT, ST_BRAKE});
         o_chain_permit_out <= (seq_r == ST_SPINUP) ? 1'b0 : chain_in_s;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_drive_ready <= RST_LOW;
         o_ready_lamp <= RST_LOW;
      end else if (seq_r != ST_READY) begin
         o_drive_ready <= 1'b0;
         o_ready_lamp <= 1'b0;
      end else if (seq_r == ST_READY && (i_seek_done || i_recal_done || !o_heads_loaded)) begin
         o_drive_ready <= 1'b1;
         o_ready_lamp <= 1'b1;
      end else if (go_s) begin
         o_drive_ready <= 1'b0;
         o_ready_lamp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Head, zone, gates
   function automatic logic head_ok(input logic [HEAD_W-1:0] h);
      head_ok = (h <= HEAD_MAX);
   endfunction : head_ok
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_head_sel <= '0;
         o_head_sel_valid <= RST_LOW;
         o_write_level <= '0;
         o_write_en <= RST_LOW;
         o_port1_lamp <= RST_LOW;
         o_port2_lamp <= RST_LOW;
         o_unit_num <= '0;
      end else begin
         o_head_sel <= head_ok(i_head_addr) ? i_head_addr : '0;
         o_head_sel_valid <= head_ok(i_head_addr);
         o_write_level <= LEVEL_W'(i_cyl_zone >> 1);
         o_write_en <= wgate_s & ~rgate_s & head_ok(i_head_addr) & o_heads_loaded;
         o_port1_lamp <= p1_s;
         o_port2_lamp <= p2_s;
         o_unit_num <= i_plug_addr;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_offset_reached <= RST_LOW;
      end else if (ofs_rst_s || go_s) begin
         o_offset_reached <= 1'b0;
      end else if (i_at_offset) begin
         o_offset_reached <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Locked oscillator and bit clocks
   logic [OSC_CNT_W-1:0] osc_cnt_r;
   logic osc_r;
   logic osc_fall;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         osc_cnt_r <= '0;
         osc_r <= RST_LOW;
      end else if (osc_cnt_r == OSC_CNT_W'(OSC_HALF_CYC - 1)) begin
         osc_cnt_r <= '0;
         osc_r <= ~osc_r;
      end else begin
         osc_cnt_r <= osc_cnt_r + 1'b1;
      end
   end
   // First cycle after the oscillator falls, aligned with the read strobe fall
   assign osc_fall = !osc_r && (osc_cnt_r == '0);
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_osc_clk <= RST_LOW;
         o_read_clk <= RST_LOW;
         o_write_bit <= RST_LOW;
         o_data_out <= RST_LOW;
         o_data_oe_b <= RST_HIGH;
      end else begin
         o_osc_clk <= osc_r & wgate_s;
         o_read_clk <= osc_r & rgate_s;
         o_data_oe_b <= ~(rgate_s & ~wgate_s);
         if (rgate_s && osc_fall) begin
            o_data_out <= i_read_bit;
         end
         if (wgate_s && osc_r && osc_cnt_r == '0) begin
            o_write_bit <= i_data_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_offset_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (ofs_rst_s || go_s) |=> !o_offset_reached) else $error("offset not dropped");
   a_index_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_index_pulse && !i_index_bad) |=> !o_index_fault) else $error("index fault held");
   a_stop_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      i_stop_cond |=> o_safety_stop) else $error("stop latch not set");
   a_timeout_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_recal_done && !i_seek_timeout) |=> !o_seek_timeout) else $error("timeout held");
   a_servo_block: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_head_sel_valid |-> o_head_sel <= HEAD_MAX) else $error("servo head chosen");
   a_ready_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (seq_r == ST_RETRACT) |=> !o_drive_ready && !o_heads_loaded) else $error("ready kept");
   a_chain_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (seq_r == ST_SPINUP) |=> !o_chain_permit_out) else $error("chain permit high");
   a_write_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !wgate_s |=> !o_write_en && !o_osc_clk) else $error("write without gate");
   a_read_clk: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !rgate_s |=> !o_read_clk && o_data_oe_b) else $error("read clock without gate");
   a_start_cond: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (seq_r == ST_IDLE && !start_ok) |=> seq_r == ST_IDLE) else $error("bad start");
endmodule : dhi_ctrl

/* File: pkg/dhi_pkg.sv */
/*
 Constants for the disc drive host interface control block.
 Assumes a 50 MHz reference clock; all counts derive from it.
*/
package dhi_pkg;
   // Reference clock
   localparam int unsigned REF_CLK_KHZ = 50000;
   // Locked oscillator rate, pulses per second (1.9 megapulses/second)
   localparam int unsigned OSC_PPS = 1900000;
   // Half period of the locked oscillator in reference cycles, rounded down
   localparam int unsigned OSC_HALF_CYC = (REF_CLK_KHZ * 1000) / (2 * OSC_PPS);
   localparam int unsigned OSC_CNT_W = 8;
   // Widths
   localparam int unsigned HEAD_W = 5;
   localparam int unsigned ZONE_W = 3;
   localparam int unsigned UNIT_W = 3;
   localparam int unsigned LEVEL_W = 2;
   // Highest addressable data head; the servo head sits above it
   localparam logic [4:0] HEAD_MAX = 5'h12;
   localparam logic [4:0] HEAD_SERVO = 5'h13;
   // Reset values
   localparam logic RST_LOW = 1'b0;
   localparam logic RST_HIGH = 1'b1;
endpackage : dhi_pkg

/* File: verif/dhi_host_model.sv */
/*
 Host controller model for the serial data line of the drive interface.
 Assumes the bench drives the command levels; this model only moves bits.
*/
`timescale 1ns/1ps
module dhi_host_model (
   // Write gate from the bench, strobes from the drive
   input wire logic i_write_gate,
   input wire logic i_osc_clk,
   input wire logic i_read_clk,
   // Serial line
   input wire logic i_data_line,
   input wire logic i_data_oe_b,
   output logic o_data_in,
   // Collected read bits
   output logic [7:0] o_rx_bits
);
   logic [7:0] tx_pat_r;
   initial begin
      o_data_in = 1'b0;
      o_rx_bits = 8'h00;
      tx_pat_r = 8'hb4;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Write data changes on the falling strobe edge
   always @(negedge i_osc_clk) begin
      if (i_write_gate) begin
         o_data_in <= tx_pat_r[7];
         tx_pat_r <= {tx_pat_r[6:0], tx_pat_r[7]};
      end
   end
   // Released line shows the inverse of its last level
   always @(negedge i_write_gate) begin
      o_data_in <= ~o_data_in;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read data taken at the rising read strobe
   always @(posedge i_read_clk) begin
      if (!i_data_oe_b) begin
         o_rx_bits <= {o_rx_bits[6:0], i_data_line};
      end
   end
endmodule : dhi_host_model

/* File: verif/tb.sv */
/*
 Self-checking bench for the drive interface control block.
 Assumes 50 MHz reference clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module tb;
   import dhi_pkg::*;
   logic i_ref_clk = 0, i_rst_b = 0, i_standby_req = 0, i_head_load_permit = 0;
   logic i_powerup_chain_input = 0, i_chain_permit_in = 0, i_read_gate = 0, i_write_gate = 0;
   logic [HEAD_W-1:0] i_head_addr = 5'h00;
   logic [ZONE_W-1:0] i_cyl_zone = 3'h0;
   logic i_port1_ind = 0, i_port2_ind = 0, i_offset_reset = 0, i_motion_go = 0;
   logic i_start_req = 0, i_pack_present = 0, i_door_closed = 0, i_at_speed = 0;
   logic i_fully_retracted = 0, i_heads_loaded_mech = 0, i_stop_cond = 0, i_index_pulse = 0;
   logic i_index_bad = 0, i_seek_timeout = 0, i_recal_done = 0, i_seek_done = 0;
   logic i_at_offset = 0, i_read_bit = 0;
   logic [UNIT_W-1:0] i_plug_addr = 3'h0;
   wire logic i_data_in;
   logic o_data_out, o_data_oe_b, o_drive_ready, o_heads_loaded, o_carriage_home;
   logic o_offset_reached, o_index_fault, o_safety_stop, o_seek_timeout, o_chain_permit_out;
   logic o_osc_clk, o_read_clk, o_retract, o_load_heads, o_brake, o_spindle_on;
   logic o_recal_launch, o_write_en, o_write_bit, o_head_sel_valid, o_standby_lamp;
   logic o_ready_lamp, o_port1_lamp, o_port2_lamp;
   logic [UNIT_W-1:0] o_unit_num;
   logic [HEAD_W-1:0] o_head_sel;
   logic [LEVEL_W-1:0] o_write_level;
   logic [7:0] rx_bits;
   logic prev_out, v;
   int failures = 0, cmp_count = 0, cycles = 0, launches = 0, n;
   logic [5:0] h;
   ////////////////////////////////////////////////////////////////////////////
   dhi_ctrl dhi_ctrl_inst (.i_ref_clk, .i_rst_b, .i_standby_req, .i_head_load_permit,
      .i_powerup_chain_input, .i_chain_permit_in, .i_read_gate, .i_write_gate, .i_head_addr,
      .i_cyl_zone, .i_port1_ind, .i_port2_ind, .i_offset_reset, .i_motion_go, .i_data_in,
      .o_data_out, .o_data_oe_b, .i_start_req, .i_pack_present, .i_door_closed, .i_at_speed,
      .i_fully_retracted, .i_heads_loaded_mech, .i_stop_cond, .i_index_pulse, .i_index_bad,
      .i_seek_timeout, .i_recal_done, .i_seek_done, .i_at_offset, .i_read_bit, .i_plug_addr,
      .o_drive_ready, .o_heads_loaded, .o_carriage_home, .o_offset_reached, .o_index_fault,
      .o_safety_stop, .o_seek_timeout, .o_chain_permit_out, .o_osc_clk, .o_read_clk,
      .o_unit_num, .o_retract, .o_load_heads, .o_brake, .o_spindle_on, .o_recal_launch,
      .o_write_en, .o_write_bit, .o_head_sel, .o_head_sel_valid, .o_write_level,
      .o_standby_lamp, .o_ready_lamp, .o_port1_lamp, .o_port2_lamp);
   dhi_host_model dhi_host_model_inst (.i_write_gate(i_write_gate), .i_osc_clk(o_osc_clk),
      .i_read_clk(o_read_clk), .i_data_line(o_data_out), .i_data_oe_b(o_data_oe_b),
      .o_data_in(i_data_in), .o_rx_bits(rx_bits));
   ////////////////////////////////////////////////////////////////////////////
   always #10 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      prev_out <= o_data_out;
      cycles <= cycles + 1;
      if (o_recal_launch === 1'b1) launches <= launches + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge i_ref_clk);
   endtask : cyc
   task automatic start_pulse;
      i_start_req = 1;
      cyc(4);
      i_start_req = 0;
      cyc(5);
   endtask : start_pulse
   task automatic complete_run;
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(8);
      chk("rst_rdy", o_drive_ready, 8'h00);
      chk("rst_oe", o_data_oe_b, 8'h01);
      chk("rst_chain", o_chain_permit_out, 8'h00);
      cyc(8);
      i_rst_b = 1;
      i_plug_addr = 3'h5;
      i_port1_ind = 1;
      cyc(5);
      chk("unit", o_unit_num, 8'h05);
      chk("p1", {o_port1_lamp, o_port2_lamp}, 8'h02);
      for (h = 6'h00; h < 6'h08; h++) begin
         i_cyl_zone = h[2:0];
         cyc(5);
         chk("lvl", o_write_level, {5'h00, h[2:0]} >> 1);
      end
      for (h = 6'h00; h < 6'h20; h++) begin
         i_head_addr = h[4:0];
         cyc(5);
         chk("hok", o_head_sel_valid, {7'h00, h[4:0] <= HEAD_MAX});
         if (h[4:0] <= HEAD_MAX) chk("hsel", o_head_sel, h);
      end
      i_index_bad = 1;
      cyc(1);
      i_index_bad = 0;
      cyc(3);
      chk("idx", o_index_fault, 8'h01);
      i_index_pulse = 1;
      cyc(1);
      i_index_pulse = 0;
      cyc(3);
      chk("idx", o_index_fault, 8'h00);
      i_stop_cond = 1;
      cyc(3);
      start_pulse();
      chk("stop", o_safety_stop, 8'h01);
      i_stop_cond = 0;
      cyc(3);
      chk("stop", o_safety_stop, 8'h01);
      start_pulse();
      chk("stop", o_safety_stop, 8'h00);
      i_seek_timeout = 1;
      cyc(4);
      chk("sto", {o_seek_timeout, 7'(launches)}, 8'h81);
      i_seek_timeout = 0;
      i_recal_done = 1;
      cyc(2);
      i_recal_done = 0;
      cyc(3);
      chk("sto", o_seek_timeout, 8'h00);
      i_head_load_permit = 1;
      i_powerup_chain_input = 1;
      i_pack_present = 1;
      i_door_closed = 1;
      start_pulse();
      chk("spin", o_spindle_on, 8'h00);
      i_chain_permit_in = 1;
      cyc(4);
      start_pulse();
      chk("spin", {o_spindle_on, o_chain_permit_out}, 8'h02);
      i_at_speed = 1;
      cyc(6);
      chk("chain", {o_chain_permit_out, o_load_heads}, 8'h03);
      i_heads_loaded_mech = 1;
      cyc(6);
      chk("rdy", {o_drive_ready, o_ready_lamp, o_heads_loaded}, 8'h07);
      i_at_offset = 1;
      cyc(4);
      chk("ofs", o_offset_reached, 8'h01);
      i_offset_reset = 1;
      cyc(4);
      chk("ofs", o_offset_reached, 8'h00);
      i_offset_reset = 0;
      i_at_offset = 0;
      cyc(4);
      i_at_offset = 1;
      cyc(4);
      chk("ofs", o_offset_reached, 8'h01);
      i_motion_go = 1;
      cyc(4);
      chk("ofs", o_offset_reached, 8'h00);
      chk("rdy", o_drive_ready, 8'h00);
      i_motion_go = 0;
      i_at_offset = 0;
      cyc(4);
      i_seek_done = 1;
      cyc(1);
      i_seek_done = 0;
      cyc(3);
      chk("rdy", o_drive_ready, 8'h01);
      i_head_addr = 5'h03;
      i_write_gate = 1;
      cyc(5);
      chk("wr", {o_write_en, o_data_oe_b, 3'(o_head_sel)}, 8'h1b);
      @(posedge o_osc_clk);
      n = 0;
      @(negedge i_ref_clk);
      while (o_osc_clk === 1'b1 && n < 100) begin
         n++;
         @(negedge i_ref_clk);
      end
      chk("osc", 8'(n), 8'(OSC_HALF_CYC));
      repeat (6) begin
         @(posedge o_osc_clk);
         v = i_data_in;
         cyc(3);
         chk("wbit", o_write_bit, {7'h00, v});
      end
      i_write_gate = 0;
      cyc(30);
      for (n = 0; n < 30; n++) begin
         cyc(1);
         chk("osc_idle", {o_osc_clk, o_write_en}, 8'h00);
      end
      i_read_bit = 1;
      i_read_gate = 1;
      cyc(5);
      chk("oe", o_data_oe_b, 8'h00);
      for (n = 0; n < 20; n++) begin
         if (n == 10) chk("rx", rx_bits, 8'hff);
         if (n == 10) i_read_bit = 0;
         @(posedge o_read_clk);
         cyc(1);
         chk("rdat", o_data_out, {7'h00, prev_out});
         if (n > 0) chk("rbit", o_data_out, {7'h00, i_read_bit});
      end
      chk("rx", rx_bits, 8'h00);
      i_read_gate = 0;
      cyc(30);
      chk("oe", {o_data_oe_b, o_read_clk}, 8'h02);
      i_standby_req = 1;
      cyc(6);
      chk("stby", {o_standby_lamp, o_retract, o_drive_ready, o_ready_lamp}, 8'h0c);
      chk("stby", {o_heads_loaded, o_carriage_home, o_brake}, 8'h00);
      i_heads_loaded_mech = 0;
      i_fully_retracted = 1;
      cyc(6);
      chk("home", {o_carriage_home, o_brake}, 8'h03);
      i_standby_req = 0;
      i_chain_permit_in = 0;
      cyc(4);
      start_pulse();
      chk("stby", o_standby_lamp, 8'h01);
      i_chain_permit_in = 1;
      cyc(4);
      start_pulse();
      chk("stby", o_standby_lamp, 8'h00);
      complete_run();
   end
endmodule : tb
